/* verif/tb.sv */
module tb
    import timebase_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FACTOR = 1000;
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_start = 1'b0;
    logic i_fire = 1'b0;
    logic [DIV_W-1:0] i_divide = DIV_RESET;
    logic [CNT_W-1:0] i_pre_count = CNT_ZERO;
    logic [CNT_W-1:0] i_post_count = CNT_ZERO;
    logic i_qualified_trigger, i_stretch_done, o_sample_clk, o_arm, o_interp_pulse;
    logic o_acq_done, o_running, o_ivl_valid;
    logic [IVL_W-1:0] o_ivl_count;
    int bad_count = 0;
    int checks_done = 0;
    int ticks;
    localparam int W_ARM = 0;
    localparam int W_SCLK = 1;
    localparam int W_PULSE = 2;
    localparam int W_VALID = 3;
    localparam int W_DONE = 4;
    acquisition_timebase_sequencer i_acquisition_timebase_sequencer (.i_clk, .i_rst,
        .i_start, .i_divide, .i_pre_count, .i_post_count, .i_qualified_trigger,
        .i_stretch_done, .o_sample_clk, .o_arm, .o_interp_pulse, .o_acq_done,
        .o_running, .o_ivl_valid, .o_ivl_count);
    trig_partner #(.FACTOR(FACTOR)) i_trig_partner (.i_clk, .i_fire, .i_arm(o_arm),
        .i_interp_pulse(o_interp_pulse), .o_qualified_trigger(i_qualified_trigger),
        .o_stretch_done(i_stretch_done), .i_sample_clk(o_sample_clk), .o_ticks(ticks));
    // ****************************************************************
    // helpers
    // ****************************************************************
    initial forever #10 i_clk = ~i_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    function automatic logic probe(input int sel);
        case (sel)
            W_ARM: return o_arm;
            W_SCLK: return o_sample_clk;
            W_PULSE: return o_interp_pulse;
            W_VALID: return o_ivl_valid;
            default: return o_acq_done;
        endcase
    endfunction : probe
    task automatic wait_lvl(input int sel, input logic v, input int lim, output int n);
        n = 0;
        while (probe(sel) !== v) begin
            @(negedge i_clk);
            n++;
            if (n > lim) begin
                bad_count++;
                results();
            end
        end
    endtask : wait_lvl
    // ****************************************************************
    // one acquisition
    // ****************************************************************
    task automatic acquire(input int pre, input int post, input int div);
        int n;
        int w;
        int t0;
        i_divide = div[DIV_W-1:0];
        i_pre_count = pre[CNT_W-1:0];
        i_post_count = post[CNT_W-1:0];
        i_start = 1'b1;
        @(negedge i_clk);
        i_start = 1'b0;
        t0 = ticks;
        // a long pre phase leaves room for a trigger that must be ignored
        if (pre > 4) begin
            i_fire = 1'b1;
            repeat (5) @(negedge i_clk);
            i_fire = 1'b0;
        end
        check(o_interp_pulse, 0);
        wait_lvl(W_ARM, 1, 999, n);
        if (pre > 0) check(ticks - t0, pre);
        // time one whole high phase, whatever phase the clock is in now
        wait_lvl(W_SCLK, 0, 64, n);
        wait_lvl(W_SCLK, 1, 64, n);
        wait_lvl(W_SCLK, 0, 64, n);
        check(n, div + 1);
        i_fire = 1'b1;
        wait_lvl(W_PULSE, 1, 9, n);
        t0 = ticks;
        wait_lvl(W_PULSE, 0, 99, w);
        check(ticks - t0, 1);
        check(w <= 2 * (div + 1), 1);
        i_fire = 1'b0;
        wait_lvl(W_VALID, 1, 9999, n);
        check(o_ivl_count >= w * FACTOR && o_ivl_count <= w * FACTOR + 4, 1);
        wait_lvl(W_DONE, 1, 9999, n);
        check(ticks - t0, post);
        check(o_running | o_sample_clk, 0);
    endtask : acquire
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst = 1'b0;
        @(negedge i_clk);
        check(o_running | o_arm | o_acq_done | o_ivl_valid, 0);
        acquire(0, 1, 0);
        acquire(6, 3, 1);
        acquire(2, 2, 0);
        results();
    end
endmodule : tb
bind acquisition_timebase_sequencer timebase_checker #(.CNTW(CNTW), .IVLW(IVLW))
    i_timebase_checker (.i_clk, .i_rst, .i_start, .i_pre_count, .o_sample_clk, .o_arm,
    .o_interp_pulse, .o_acq_done, .o_running, .o_ivl_valid, .o_ivl_count);

/* verif/timebase_checker.sv */
module timebase_checker
    import timebase_pkg::*;
#(
    parameter int CNTW = CNT_W,
    parameter int IVLW = IVL_W
) (
    input wire logic i_clk, // clock
    input wire logic i_rst, // reset
    input wire logic i_start, // start
    input wire logic [CNTW-1:0] i_pre_count, // pre count
    input wire logic o_sample_clk, // sample clock
    input wire logic o_arm, // arm
    input wire logic o_interp_pulse, // interval pulse
    input wire logic o_acq_done, // done
    input wire logic o_running, // running
    input wire logic o_ivl_valid, // count valid
    input wire logic [IVLW-1:0] o_ivl_count // count
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // port relations
    // ****************************************************************
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    property p_run; i_start && !o_running |=> o_running; endproperty
    a_run: assert property (p_run) else $error("not running after start");
    property p_arm0; i_start && !o_running && i_pre_count == '0 |-> ##2 o_arm; endproperty
    a_arm0: assert property (p_arm0) else $error("arm late");
    property p_take; $rose(o_interp_pulse) |-> $fell(o_arm); endproperty
    a_take: assert property (p_take) else $error("arm kept");
    property p_clr; $rose(o_interp_pulse) |-> !o_ivl_valid; endproperty
    a_clr: assert property (p_clr) else $error("valid kept");
    // divider settings in the bench keep a period under 64 cycles
    property p_plen; $rose(o_interp_pulse) |-> ##[1:64] !o_interp_pulse; endproperty
    a_plen: assert property (p_plen) else $error("pulse too long");
    property p_done; $rose(o_acq_done) |-> $fell(o_running); endproperty
    a_done: assert property (p_done) else $error("clocks not stopped");
    property p_hold; o_acq_done && !i_start |=> o_acq_done; endproperty
    a_hold: assert property (p_hold) else $error("done dropped");
    property p_stop; !o_running |-> !o_sample_clk && !o_arm; endproperty
    a_stop: assert property (p_stop) else $error("clock while stopped");
    property p_keep; o_ivl_valid && $past(o_ivl_valid) |-> $stable(o_ivl_count); endproperty
    a_keep: assert property (p_keep) else $error("count moved");
endmodule : timebase_checker

/* verif/trig_partner.sv */
module trig_partner #(
    parameter int FACTOR = 1000
) (
    input wire logic i_clk, // clock
    input wire logic i_fire, // trigger condition met
    input wire logic i_arm, // arm from sequencer
    input wire logic i_interp_pulse, // interval pulse
    input wire logic i_sample_clk, // supplied sample clock
    output logic o_qualified_trigger = 1'b0, // trigger
    output logic o_stretch_done = 1'b0, // stretch finished
    output int o_ticks = 0 // supplied edges the sampling stage locked onto
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // logic trigger and stretcher
    // ****************************************************************
    int width = 0;
    int left = 0;
    always @(posedge i_clk) begin
        o_qualified_trigger <= i_fire;
        // dropped on arm so the flag is low before any next trigger
        if (i_arm) o_stretch_done <= 1'b0;
        if (left != 0) left <= left - 1;
        if (left == 1) o_stretch_done <= 1'b1;
        if (i_interp_pulse) width <= width + 1;
        else if (width != 0) begin
            left <= width * FACTOR;
            width <= 0;
        end
    end
    // the sampling stage counts each supplied rising edge once, with no multiplication
    always @(posedge i_sample_clk) o_ticks <= o_ticks + 1;
endmodule : trig_partner

/* verilog/acquisition_timebase_sequencer.sv */
// Summary of operation
// - the fast clock input is the 100 MHz reference for all sample timing.
// - sample clock enable comes from a programmable divider chosen per time range.
// - after the programmed pre-trigger samples, arm is raised to the logic trigger.
// - a qualified trigger starts the post-trigger countdown from the loaded count.
// - at countdown zero sample clocks stop and acquisition complete is signalled.
// - one interpolator pulse spans trigger to the next rising sample clock edge.
// - an interval counter on the reference runs during the stretch, stops at end.
// - the final interval count is held for software to place samples.
module acquisition_timebase_sequencer
    import timebase_pkg::*;
#(
    parameter int DIVW = DIV_W,
    parameter int CNTW = CNT_W,
    parameter int IVLW = IVL_W
) (
    input wire logic i_clk, // 100 MHz reference
    input wire logic i_rst, // synchronous, active high
    input wire logic i_start, // cpu: begin an acquisition (pulse)
    input wire logic [DIVW-1:0] i_divide, // divider setting for time range
    input wire logic [CNTW-1:0] i_pre_count, // pre-trigger samples
    input wire logic [CNTW-1:0] i_post_count, // post-trigger samples
    input wire logic i_qualified_trigger, // from logic trigger, async
    input wire logic i_stretch_done, // from interpolator, async
    output logic o_sample_clk, // sample clock to sampling stage
    output logic o_arm, // ready for trigger
    output logic o_interp_pulse, // trigger-to-sample interval pulse
    output logic o_acq_done, // acquisition complete (level)
    output logic o_running, // sample clocks running
    output logic o_ivl_valid, // interval count is valid
    output logic [IVLW-1:0] o_ivl_count // stored interval count
);
    // ****************************************************************
    // parameter checks
    // ****************************************************************
    if (DIVW < 1 || DIVW > 32 || CNTW < 1 || CNTW > 32 || IVLW < 1 || IVLW > 32) begin : g_chk
        $error("timebase widths out of range");
    end

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [1:0] trig_sync_reg, trig_sync_next;
    logic [1:0] str_sync_reg, str_sync_next;
    logic trig_prev_reg, trig_prev_next;

    always_comb begin
        trig_sync_next = {trig_sync_reg[0], i_qualified_trigger};
        str_sync_next = {str_sync_reg[0], i_stretch_done};
        trig_prev_next = trig_sync_reg[1];
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            trig_sync_reg <= 2'b00;
            str_sync_reg <= 2'b00;
            trig_prev_reg <= 1'b0;
        end else begin
            trig_sync_reg <= trig_sync_next;
            str_sync_reg <= str_sync_next;
            trig_prev_reg <= trig_prev_next;
        end
    end

    // edge detect on the second stage only
    wire trig_rise = trig_sync_reg[1] & ~trig_prev_reg;
    wire stretch_end = str_sync_reg[1];

    // ****************************************************************
    // sample clock divider
    // ****************************************************************
    // a setting of zero divides by two; the output toggles each time the count reaches divide, so
    // the sample rate is ref / (2*(divide+1)), the tick is the rising edge
    seq_state_t st_reg, st_next;
    logic [CNTW-1:0] cnt_reg, cnt_next;
    logic [DIVW-1:0] div_cnt_reg, div_cnt_next;
    logic sclk_reg, sclk_next;
    logic run_reg, run_next;
    logic tick;
    logic stop_now;

    always_comb begin
        div_cnt_next = div_cnt_reg;
        sclk_next = sclk_reg;
        tick = 1'b0;
        // the stopping edge parks the clock low too, so it never stands high once running drops
        stop_now = (st_reg == ST_POST) && (cnt_reg == CNTW'(0));
        if (!run_reg || stop_now) begin
            div_cnt_next = DIVW'(0);
            sclk_next = 1'b0;
        end else if (div_cnt_reg >= i_divide) begin
            div_cnt_next = DIVW'(0);
            sclk_next = ~sclk_reg;
            tick = ~sclk_reg;
        end else begin
            div_cnt_next = div_cnt_reg + DIVW'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            div_cnt_reg <= DIVW'(0);
            sclk_reg <= 1'b0;
        end else begin
            div_cnt_reg <= div_cnt_next;
            sclk_reg <= sclk_next;
        end
    end

    // ****************************************************************
    // acquisition sequencer
    // ****************************************************************
    logic arm_reg, arm_next;
    logic done_reg, done_next;
    logic trig_take;

    always_comb begin
        st_next = st_reg;
        cnt_next = cnt_reg;
        arm_next = arm_reg;
        done_next = done_reg;
        run_next = run_reg;
        trig_take = 1'b0;
        case (st_reg)
            ST_IDLE, ST_DONE: begin
                if (i_start) begin
                    st_next = ST_PRE;
                    cnt_next = i_pre_count;
                    done_next = 1'b0;
                    run_next = 1'b1;
                    arm_next = 1'b0;
                end
            end
            ST_PRE: begin
                if (cnt_reg == CNTW'(0)) begin
                    st_next = ST_ARMED;
                    arm_next = 1'b1;
                end else if (tick) begin
                    cnt_next = cnt_reg - CNTW'(1);
                end
            end
            ST_ARMED: begin
                if (trig_rise && arm_reg) begin
                    trig_take = 1'b1;
                    arm_next = 1'b0;
                    st_next = ST_POST;
                    cnt_next = i_post_count;
                end
            end
            ST_POST: begin
                if (cnt_reg == CNTW'(0)) begin
                    st_next = ST_DONE;
                    run_next = 1'b0;
                    done_next = 1'b1;
                end else if (tick) begin
                    cnt_next = cnt_reg - CNTW'(1);
                end
            end
            default: begin
                st_next = ST_IDLE;
                run_next = 1'b0;
                arm_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_reg <= ST_IDLE;
            cnt_reg <= CNTW'(0);
            arm_reg <= 1'b0;
            done_reg <= 1'b0;
            run_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            cnt_reg <= cnt_next;
            arm_reg <= arm_next;
            done_reg <= done_next;
            run_reg <= run_next;
        end
    end

    // ****************************************************************
    // trigger interpolation
    // ****************************************************************
    // the counter runs on the reference, the clock the sample rate derives from
    ivl_state_t ip_reg, ip_next;
    logic pulse_reg, pulse_next;
    logic [IVLW-1:0] ivl_reg, ivl_next;
    logic [IVLW-1:0] ivl_out_reg, ivl_out_next;
    logic ivl_val_reg, ivl_val_next;

    always_comb begin
        ip_next = ip_reg;
        pulse_next = pulse_reg;
        ivl_next = ivl_reg;
        ivl_out_next = ivl_out_reg;
        ivl_val_next = ivl_val_reg;
        case (ip_reg)
            IP_IDLE: begin
                if (trig_take) begin
                    ip_next = IP_PULSE;
                    pulse_next = 1'b1;
                    ivl_val_next = 1'b0;
                    ivl_next = IVLW'(0);
                end
            end
            IP_PULSE: begin
                // stopped clocks end it too, so a zero post count cannot leave it high
                if (tick || !run_reg) begin
                    ip_next = IP_STRETCH;
                    pulse_next = 1'b0;
                end
            end
            IP_STRETCH: begin
                if (stretch_end) begin
                    ip_next = IP_DONE;
                    ivl_out_next = ivl_reg;
                    ivl_val_next = 1'b1;
                end else if (ivl_reg != {IVLW{1'b1}}) begin
                    ivl_next = ivl_reg + IVLW'(1);
                end
            end
            IP_DONE: begin
                if (!stretch_end) begin
                    ip_next = IP_IDLE;
                end
            end
            default: begin
                ip_next = IP_IDLE;
                pulse_next = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ip_reg <= IP_IDLE;
            pulse_reg <= 1'b0;
            ivl_reg <= IVLW'(0);
            ivl_out_reg <= IVLW'(0);
            ivl_val_reg <= 1'b0;
        end else begin
            ip_reg <= ip_next;
            pulse_reg <= pulse_next;
            ivl_reg <= ivl_next;
            ivl_out_reg <= ivl_out_next;
            ivl_val_reg <= ivl_val_next;
        end
    end

    assign o_sample_clk = sclk_reg;
    assign o_arm = arm_reg;
    assign o_interp_pulse = pulse_reg;
    assign o_acq_done = done_reg;
    assign o_running = run_reg;
    assign o_ivl_valid = ivl_val_reg;
    assign o_ivl_count = ivl_out_reg;
endmodule : acquisition_timebase_sequencer

/* verilog/timebase_pkg.sv */
package timebase_pkg;
    // ****************************************************************
    // reference and sizes
    // ****************************************************************
    localparam int REF_FREQ_MHZ = 100;
    localparam int DIV_W = 16;
    localparam int CNT_W = 24;
    localparam int IVL_W = 20;
    localparam int SYNC_STAGES = 2;
    localparam logic [DIV_W-1:0] DIV_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [IVL_W-1:0] IVL_ZERO = 20'h0_0000;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PRE = 3'b001,
        ST_ARMED = 3'b010,
        ST_POST = 3'b011,
        ST_DONE = 3'b100
    } seq_state_t;

    typedef enum logic [1:0] {
        IP_IDLE = 2'b00,
        IP_PULSE = 2'b01,
        IP_STRETCH = 2'b10,
        IP_DONE = 2'b11
    } ivl_state_t;
endpackage : timebase_pkg
